// ---- testbench/pmic_i2c_host_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------------
// link host, only one driving scl
// ----------------------------------------------
module pmic_i2c_host_model (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic start();
    tick(2);
    sda_low = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(2);
    sda_low = 1'b1;
    tick(2);
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(2);
    sda_low = 1'b0;
    tick(4);
  endtask
  // n bits msb first, plus the ninth bit when n is 8
  task automatic xfer(input logic [7:0] tx, input int n, input logic ninth,
    output logic [7:0] rx, output logic seen);
    logic [8:0] b;
    b = {tx, ninth};
    rx = 8'h00;
    for (int i = 0; i < n + (n == 8); i++) begin
      tick(2);
      sda_low = !b[8 - i];
      tick(2);
      scl = 1'b1;
      tick(2);
      seen = sda;
      if (i < 8) rx = {rx[6:0], sda};
      tick(2);
      scl = 1'b0;
    end
  endtask
endmodule

// ---- testbench/pmic_i2c_target_monitor.sv ----
`timescale 1ns/10ps
// ----------------------------------------------
// checker on the target's ports
// ----------------------------------------------
module pmic_i2c_target_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic sel_pin_low,
  input wire logic sel_pin_high,
  input wire logic supply_above_uvlo,
  input wire logic [7:0] ldo1_active_voltage,
  input wire logic [7:0] ldo1_hibernate_voltage,
  input wire logic [7:0] ldo1_sequencing,
  input wire logic [7:0] ldo1_configuration,
  input wire logic [7:0] ldo2_configuration
);
  logic [7:0] strap;
  logic [3:0] age_reg;
  assign strap = sel_pin_high ? 8'hb7 : sel_pin_low ? 8'h99 : 8'ha7;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) age_reg <= 4'h0;
    else if (age_reg != 4'hf) age_reg <= age_reg + 4'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_open_drain;
    !sda_out;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("sda driven high");
  property p_oe_scl_low;
    scl_in && $past(scl_in, 3) |-> $stable(sda_oe);
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("sda changed while scl high");
  property p_ack_hold;
    $rose(sda_oe) |=> sda_oe [*6];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("sda pulled too briefly");
  property p_uvlo;
    !supply_above_uvlo [*4] |-> !sda_oe;
  endproperty
  a_uvlo: assert property (p_uvlo)
    else $error("sda driven with supply low");
  property p_commit;
    $changed(ldo1_active_voltage) && age_reg == 4'hf |-> ##[0:3] sda_oe;
  endproperty
  a_commit: assert property (p_commit)
    else $error("register changed outside acknowledge");
  property p_start_quiet;
    scl_in && $past(scl_in) && $fell(sda_in) |-> !sda_oe [*8];
  endproperty
  a_start_quiet: assert property (p_start_quiet)
    else $error("sda driven during address");
  property p_defaults;
    $fell(rst) |=> ldo1_configuration == 8'ha0 &&
      ldo2_configuration == 8'ha0 && ldo1_sequencing == 8'h09;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("wrong reset value");
  property p_strap;
    $fell(rst) |=> ldo1_active_voltage == strap &&
      ldo1_hibernate_voltage == (strap & 8'h7f);
  endproperty
  a_strap: assert property (p_strap)
    else $error("wrong strap default");
  c_ack: cover property ($rose(sda_oe));
  c_commit: cover property ($changed(ldo1_active_voltage) && age_reg == 4'hf);
  c_uvlo: cover property (!supply_above_uvlo [*4]);
endmodule
bind pmic_i2c_target pmic_i2c_target_monitor u_pmic_i2c_target_monitor (
  .mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .sel_pin_low(sel_pin_low),
  .sel_pin_high(sel_pin_high), .supply_above_uvlo(supply_above_uvlo),
  .ldo1_active_voltage(ldo1_active_voltage),
  .ldo1_hibernate_voltage(ldo1_hibernate_voltage),
  .ldo1_sequencing(ldo1_sequencing),
  .ldo1_configuration(ldo1_configuration),
  .ldo2_configuration(ldo2_configuration));

// ---- testbench/pmic_i2c_target_tb.sv ----
`timescale 1ns/10ps
module pmic_i2c_target_tb;
  // ----------------------------------------------
  // wiring and reference model
  // ----------------------------------------------
  logic mclk, rst, sel_pin_low, sel_pin_high, supply_above_uvlo;
  logic scl, sda_low, sda_out, sda_oe;
  logic [7:0] q [15];
  int ofs [15] = '{8'h43, 8'h44, 8'h45, 8'h50, 8'h51, 8'h52, 8'h53,
    8'h54, 8'h55, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65};
  int mdl [256];
  int err_total, checks_done, seed, ptr;
  wire logic sda = !(sda_low | sda_oe);
  pmic_i2c_host_model u_host (.mclk(mclk), .sda(sda), .scl(scl),
    .sda_low(sda_low));
  pmic_i2c_target u_pmic_i2c_target (.mclk(mclk), .rst(rst),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .sel_pin_low(sel_pin_low), .sel_pin_high(sel_pin_high),
    .supply_above_uvlo(supply_above_uvlo),
    .buck4_highperf_voltage(q[0]), .buck4_sequencing(q[1]),
    .buck4_configuration(q[2]), .ldo1_active_voltage(q[3]),
    .ldo1_lowpower_voltage(q[4]), .ldo1_hibernate_voltage(q[5]),
    .ldo1_highperf_voltage(q[6]), .ldo1_sequencing(q[7]),
    .ldo1_configuration(q[8]), .ldo2_active_voltage(q[9]),
    .ldo2_lowpower_voltage(q[10]), .ldo2_hibernate_voltage(q[11]),
    .ldo2_highperf_voltage(q[12]), .ldo2_sequencing(q[13]),
    .ldo2_configuration(q[14]));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_regs();
    foreach (ofs[i]) chk("register", 8'(mdl[ofs[i]]), q[i]);
  endtask
  task automatic do_reset(input logic lo, input logic hi);
    int v;
    v = hi ? 8'hb7 : lo ? 8'h99 : 8'ha7;
    sel_pin_low = lo;
    sel_pin_high = hi;
    rst = 1'b1;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    foreach (mdl[i]) mdl[i] = -1;
    foreach (ofs[i]) mdl[ofs[i]] = 0;
    mdl[8'h45] = 8'ha0;
    mdl[8'h55] = 8'ha0;
    mdl[8'h65] = 8'ha0;
    mdl[8'h54] = 8'h09;
    mdl[8'h50] = v;
    mdl[8'h51] = v;
    mdl[8'h53] = v;
    mdl[8'h52] = v & 8'h7f;
    repeat (4) @(negedge mclk);
    cmp_regs();
  endtask
  task automatic wr(input logic [6:0] a, input int n, input logic [7:0] cmd,
    input int part);
    logic [7:0] rx, d;
    logic nine, hit;
    hit = (a == pmic_i2c_pkg::TARGET_ADDR) && supply_above_uvlo;
    u_host.start();
    u_host.xfer({a, 1'b0}, 8, 1'b1, rx, nine);
    chk("address ack", {7'h00, !hit}, {7'h00, nine});
    for (int i = 0; i <= n; i++) begin
      d = (i == 0) ? cmd : 8'($random(seed));
      u_host.xfer(d, 8, 1'b1, rx, nine);
      chk("data ack", {7'h00, !hit}, {7'h00, nine});
      if (hit && i == 0) ptr = d;
      else if (hit) begin
        if (mdl[ptr] >= 0) mdl[ptr] = d;
        if (ptr < 255) ptr++;
      end
    end
    if (part > 0) u_host.xfer(8'h5a, part, 1'b1, rx, nine);
    u_host.stop();
    cmp_regs();
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    logic [7:0] rx;
    logic nine;
    u_host.start();
    u_host.xfer({pmic_i2c_pkg::TARGET_ADDR, 1'b0}, 8, 1'b1, rx, nine);
    u_host.xfer(p, 8, 1'b1, rx, nine);
    u_host.start();
    u_host.xfer({pmic_i2c_pkg::TARGET_ADDR, 1'b1}, 8, 1'b1, rx, nine);
    chk("read ack", 8'h00, {7'h00, nine});
    for (int i = 0; i < n; i++) begin
      u_host.xfer(8'hff, 8, i == n - 1, rx, nine);
      chk("read data", mdl[p + i] < 0 ? 8'hff : 8'(mdl[p + i]), rx);
    end
    repeat (4) @(negedge mclk);
    chk("release", 8'h00, {7'h00, sda_oe});
    u_host.stop();
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    err_total++;
    wrap_up();
  end
  initial begin
    seed = 32'h83db;
    err_total = 0;
    checks_done = 0;
    supply_above_uvlo = 1'b1;
    do_reset(1'b0, 1'b1);
    wr(7'h5b, 1, 8'h50, 0);
    wr(7'h5b, 4, 8'h53, 0);
    wr(7'h5b, 1, 8'h30, 0);
    wr(7'h5b, 4, 8'h64, 0);
    wr(7'h5a, 1, 8'h50, 0);
    wr(7'h5b, 2, 8'h60, 4);
    rd(8'h43, 3);
    rd(8'h54, 4);
    rd(8'h64, 4);
    supply_above_uvlo = 1'b0;
    repeat (4) @(negedge mclk);
    wr(7'h5b, 1, 8'h50, 0);
    supply_above_uvlo = 1'b1;
    repeat (4) @(negedge mclk);
    wr(7'h5b, 1, 8'h51, 0);
    do_reset(1'b0, 1'b0);
    do_reset(1'b1, 1'b0);
    rd(8'h50, 4);
    wrap_up();
  end
endmodule

// ---- verilog/pmic_i2c_pkg.sv ----
package pmic_i2c_pkg;

  // ---------------------------------------------------------------
  // target address and link timing
  // ---------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR = 7'h5b;
  localparam int MCLK_HZ = 40000000;
  localparam int MAX_BIT_RATE_HZ = 1000000;
  localparam int CYCLES_PER_BIT = MCLK_HZ / MAX_BIT_RATE_HZ;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_BUCK4_HIGHPERF_VOLTAGE = 8'h43;
  localparam logic [7:0] OFS_BUCK4_SEQUENCING = 8'h44;
  localparam logic [7:0] OFS_BUCK4_CONFIGURATION = 8'h45;
  localparam logic [7:0] OFS_LDO1_ACTIVE_VOLTAGE = 8'h50;
  localparam logic [7:0] OFS_LDO1_LOWPOWER_VOLTAGE = 8'h51;
  localparam logic [7:0] OFS_LDO1_HIBERNATE_VOLTAGE = 8'h52;
  localparam logic [7:0] OFS_LDO1_HIGHPERF_VOLTAGE = 8'h53;
  localparam logic [7:0] OFS_LDO1_SEQUENCING = 8'h54;
  localparam logic [7:0] OFS_LDO1_CONFIGURATION = 8'h55;
  localparam logic [7:0] OFS_LDO2_ACTIVE_VOLTAGE = 8'h60;
  localparam logic [7:0] OFS_LDO2_LOWPOWER_VOLTAGE = 8'h61;
  localparam logic [7:0] OFS_LDO2_HIBERNATE_VOLTAGE = 8'h62;
  localparam logic [7:0] OFS_LDO2_HIGHPERF_VOLTAGE = 8'h63;
  localparam logic [7:0] OFS_LDO2_SEQUENCING = 8'h64;
  localparam logic [7:0] OFS_LDO2_CONFIGURATION = 8'h65;
  localparam logic [7:0] OFS_LAST = 8'h65;

  // ---------------------------------------------------------------
  // reset values and invalid-read data
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BUCK4_HIGHPERF_VOLTAGE = 8'h00;
  localparam logic [7:0] RST_BUCK4_SEQUENCING = 8'h00;
  localparam logic [7:0] RST_CONFIGURATION = 8'ha0;
  localparam logic [7:0] RST_LDO1_SEQUENCING = 8'h09;
  localparam logic [7:0] RST_LDO2_VOLTAGE = 8'h00;
  localparam logic [7:0] RST_LDO2_SEQUENCING = 8'h00;
  localparam logic [7:0] RST_LDO1_SEL_LOW = 8'h99;
  localparam logic [7:0] RST_LDO1_SEL_HIZ = 8'ha7;
  localparam logic [7:0] RST_LDO1_SEL_HIGH = 8'hb7;
  localparam logic [7:0] LDO1_HIBERNATE_VOLTAGE_MASK = 8'h7f;
  localparam logic [7:0] INVALID_READ = 8'hff;

  // voltage-select pin state
  typedef enum logic [1:0] {SEL_LOW, SEL_HIZ, SEL_HIGH} sel_state_t;

  localparam int NUM_REGS = 15;

endpackage

// ---- verilog/pmic_i2c_target.sv ----
`timescale 1ns/10ps

// What this block does
// - fast-mode-plus target up to 1 Mbit/s
// - target only, never stretches SCL
// - interface alive whenever supply above lockout
// - answers 7-bit address 0x5B
// - ninth clock is acknowledge, receiver pulls low
// - acknowledge every received byte when addressed
// - release SDA after host NACK
// - address MSB first, LSB gives direction
// - match address, else ignore transfer
// - first write byte loads register pointer
// - single write stores data at pointer
// - writes to invalid locations acked, no effect
// - block write increments pointer per byte
// - pointer steps by one ignoring gaps
// - each byte committed when received
// - past last register discarded, no wrap
// - LDO1 voltage defaults follow select pin
// - read via command write then repeated start
// - invalid register reads return 0xFF
// - auto-increment read streams 0xFF on gaps
module pmic_i2c_target (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sel_pin_low,
  input wire logic sel_pin_high,
  input wire logic supply_above_uvlo,
  output logic [7:0] buck4_highperf_voltage,
  output logic [7:0] buck4_sequencing,
  output logic [7:0] buck4_configuration,
  output logic [7:0] ldo1_active_voltage,
  output logic [7:0] ldo1_lowpower_voltage,
  output logic [7:0] ldo1_hibernate_voltage,
  output logic [7:0] ldo1_highperf_voltage,
  output logic [7:0] ldo1_sequencing,
  output logic [7:0] ldo1_configuration,
  output logic [7:0] ldo2_active_voltage,
  output logic [7:0] ldo2_lowpower_voltage,
  output logic [7:0] ldo2_hibernate_voltage,
  output logic [7:0] ldo2_highperf_voltage,
  output logic [7:0] ldo2_sequencing,
  output logic [7:0] ldo2_configuration
);

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  localparam int NUMR = pmic_i2c_pkg::NUM_REGS;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
  } phase_t;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] uv_sync;
    logic scl_d;
    logic sda_d;
    logic strap_pending;
    phase_t phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic have_cmd;
    logic [7:0] ptr;
    logic [7:0] tx_byte;
    logic sda_out;
    logic sda_oe;
    logic [NUMR*8-1:0] regs;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  function automatic logic [4:0] reg_index(input logic [7:0] ofs);
    case (ofs)
      pmic_i2c_pkg::OFS_BUCK4_HIGHPERF_VOLTAGE: reg_index = 5'd0;
      pmic_i2c_pkg::OFS_BUCK4_SEQUENCING: reg_index = 5'd1;
      pmic_i2c_pkg::OFS_BUCK4_CONFIGURATION: reg_index = 5'd2;
      pmic_i2c_pkg::OFS_LDO1_ACTIVE_VOLTAGE: reg_index = 5'd3;
      pmic_i2c_pkg::OFS_LDO1_LOWPOWER_VOLTAGE: reg_index = 5'd4;
      pmic_i2c_pkg::OFS_LDO1_HIBERNATE_VOLTAGE: reg_index = 5'd5;
      pmic_i2c_pkg::OFS_LDO1_HIGHPERF_VOLTAGE: reg_index = 5'd6;
      pmic_i2c_pkg::OFS_LDO1_SEQUENCING: reg_index = 5'd7;
      pmic_i2c_pkg::OFS_LDO1_CONFIGURATION: reg_index = 5'd8;
      pmic_i2c_pkg::OFS_LDO2_ACTIVE_VOLTAGE: reg_index = 5'd9;
      pmic_i2c_pkg::OFS_LDO2_LOWPOWER_VOLTAGE: reg_index = 5'd10;
      pmic_i2c_pkg::OFS_LDO2_HIBERNATE_VOLTAGE: reg_index = 5'd11;
      pmic_i2c_pkg::OFS_LDO2_HIGHPERF_VOLTAGE: reg_index = 5'd12;
      pmic_i2c_pkg::OFS_LDO2_SEQUENCING: reg_index = 5'd13;
      pmic_i2c_pkg::OFS_LDO2_CONFIGURATION: reg_index = 5'd14;
      default: reg_index = 5'd31;
    endcase
  endfunction

  // reset image; LDO1 voltages chosen by the select pin
  function automatic logic [NUMR*8-1:0] defaults(input logic lo,
                                                 input logic hi);
    logic [7:0] v;
    logic [NUMR*8-1:0] d;
    v = pmic_i2c_pkg::RST_LDO1_SEL_HIZ;
    if (lo) begin
      v = pmic_i2c_pkg::RST_LDO1_SEL_LOW;
    end else if (hi) begin
      v = pmic_i2c_pkg::RST_LDO1_SEL_HIGH;
    end
    d = '0;
    d[0*8 +: 8] = pmic_i2c_pkg::RST_BUCK4_HIGHPERF_VOLTAGE;
    d[1*8 +: 8] = pmic_i2c_pkg::RST_BUCK4_SEQUENCING;
    d[2*8 +: 8] = pmic_i2c_pkg::RST_CONFIGURATION;
    d[3*8 +: 8] = v;
    d[4*8 +: 8] = v;
    d[5*8 +: 8] = v & pmic_i2c_pkg::LDO1_HIBERNATE_VOLTAGE_MASK;
    d[6*8 +: 8] = v;
    d[7*8 +: 8] = pmic_i2c_pkg::RST_LDO1_SEQUENCING;
    d[8*8 +: 8] = pmic_i2c_pkg::RST_CONFIGURATION;
    d[9*8 +: 8] = pmic_i2c_pkg::RST_LDO2_VOLTAGE;
    d[10*8 +: 8] = pmic_i2c_pkg::RST_LDO2_VOLTAGE;
    d[11*8 +: 8] = pmic_i2c_pkg::RST_LDO2_VOLTAGE;
    d[12*8 +: 8] = pmic_i2c_pkg::RST_LDO2_VOLTAGE;
    d[13*8 +: 8] = pmic_i2c_pkg::RST_LDO2_SEQUENCING;
    d[14*8 +: 8] = pmic_i2c_pkg::RST_CONFIGURATION;
    defaults = d;
  endfunction

  function automatic logic [7:0] read_reg(input logic [NUMR*8-1:0] r,
                                          input logic [7:0] ofs);
    logic [4:0] i;
    i = reg_index(ofs);
    if (i == 5'd31) begin
      read_reg = pmic_i2c_pkg::INVALID_READ;
    end else begin
      read_reg = r[i*8 +: 8];
    end
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [4:0] widx;
  logic [7:0] rd_byte;

  always_comb begin
    st_next = st_reg;
    widx = 5'd31;
    rd_byte = read_reg(st_reg.regs, st_reg.ptr);
    st_next.scl_sync = {st_reg.scl_sync[0], scl_in};
    st_next.sda_sync = {st_reg.sda_sync[0], sda_in};
    st_next.uv_sync = {st_reg.uv_sync[0], supply_above_uvlo};
    st_next.scl_d = st_reg.scl_sync[1];
    st_next.sda_d = st_reg.sda_sync[1];
    scl_rise = st_reg.scl_sync[1] && !st_reg.scl_d;
    scl_fall = !st_reg.scl_sync[1] && st_reg.scl_d;
    start_cond = st_reg.scl_sync[1] && st_reg.scl_d &&
                 st_reg.sda_d && !st_reg.sda_sync[1];
    stop_cond = st_reg.scl_sync[1] && st_reg.scl_d &&
                !st_reg.sda_d && st_reg.sda_sync[1];

    // strap caught one cycle after reset release
    if (st_reg.strap_pending) begin
      st_next.strap_pending = 1'b0;
      st_next.regs = defaults(sel_pin_low, sel_pin_high);
    end

    if (!st_reg.uv_sync[1]) begin
      st_next.phase = ST_IDLE;
      st_next.sda_oe = 1'b0;
    end else if (start_cond) begin
      st_next.phase = ST_ADDR;
      st_next.bit_cnt = 4'd0;
      st_next.sda_oe = 1'b0;
    end else if (stop_cond) begin
      st_next.phase = ST_IDLE;
      st_next.have_cmd = 1'b0;
      st_next.sda_oe = 1'b0;
    end else begin
      case (st_reg.phase)
        ST_IDLE: begin
          st_next.sda_oe = 1'b0;
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            st_next.shift = {st_reg.shift[6:0], st_reg.sda_sync[1]};
            st_next.bit_cnt = st_reg.bit_cnt + 4'd1;
          end else if (scl_fall && st_reg.bit_cnt == 4'd8) begin
            st_next.bit_cnt = 4'd0;
            if (st_reg.phase == ST_ADDR) begin
              if (st_reg.shift[7:1] == pmic_i2c_pkg::TARGET_ADDR) begin
                st_next.phase = ST_ADDR_ACK;
                st_next.sda_oe = 1'b1;
              end else begin
                st_next.phase = ST_IDLE;
              end
            end else begin
              st_next.phase = ST_RX_ACK;
              st_next.sda_oe = 1'b1;
              if (!st_reg.have_cmd) begin
                st_next.ptr = st_reg.shift;
                st_next.have_cmd = 1'b1;
              end else begin
                widx = reg_index(st_reg.ptr);
                if (widx != 5'd31) begin
                  st_next.regs[widx*8 +: 8] = st_reg.shift;
                end
                if (st_reg.ptr != 8'hff) begin
                  st_next.ptr = st_reg.ptr + 8'd1;
                end
              end
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (st_reg.shift[0]) begin
              st_next.phase = ST_TX;
              st_next.tx_byte = rd_byte;
              st_next.sda_oe = !rd_byte[7];
            end else begin
              st_next.phase = ST_RX;
              st_next.sda_oe = 1'b0;
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            st_next.phase = ST_RX;
            st_next.sda_oe = 1'b0;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            st_next.bit_cnt = st_reg.bit_cnt + 4'd1;
            if (st_reg.bit_cnt == 4'd7) begin
              st_next.phase = ST_TX_ACK;
              st_next.sda_oe = 1'b0;
              if (st_reg.ptr != 8'hff) begin
                st_next.ptr = st_reg.ptr + 8'd1;
              end
            end else begin
              st_next.tx_byte = {st_reg.tx_byte[6:0], 1'b1};
              st_next.sda_oe = !st_reg.tx_byte[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            st_next.shift[0] = st_reg.sda_sync[1];
          end else if (scl_fall) begin
            st_next.bit_cnt = 4'd0;
            if (st_reg.shift[0]) begin
              st_next.phase = ST_IDLE;
              st_next.sda_oe = 1'b0;
            end else begin
              st_next.phase = ST_TX;
              st_next.tx_byte = rd_byte;
              st_next.sda_oe = !rd_byte[7];
            end
          end
        end
        default: begin
          st_next.phase = ST_IDLE;
        end
      endcase
    end
    // open drain: only ever drives low, SCL is never driven
    st_next.sda_out = 1'b0;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '{scl_sync: 2'b11, sda_sync: 2'b11, uv_sync: 2'b00,
                  scl_d: 1'b1, sda_d: 1'b1, strap_pending: 1'b1,
                  phase: ST_IDLE, bit_cnt: 4'd0, shift: 8'h00,
                  have_cmd: 1'b0, ptr: 8'h00, tx_byte: 8'hff,
                  sda_out: 1'b0, sda_oe: 1'b0, regs: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign sda_out = st_reg.sda_out;
  assign sda_oe = st_reg.sda_oe;
  assign buck4_highperf_voltage = st_reg.regs[0*8 +: 8];
  assign buck4_sequencing = st_reg.regs[1*8 +: 8];
  assign buck4_configuration = st_reg.regs[2*8 +: 8];
  assign ldo1_active_voltage = st_reg.regs[3*8 +: 8];
  assign ldo1_lowpower_voltage = st_reg.regs[4*8 +: 8];
  assign ldo1_hibernate_voltage = st_reg.regs[5*8 +: 8];
  assign ldo1_highperf_voltage = st_reg.regs[6*8 +: 8];
  assign ldo1_sequencing = st_reg.regs[7*8 +: 8];
  assign ldo1_configuration = st_reg.regs[8*8 +: 8];
  assign ldo2_active_voltage = st_reg.regs[9*8 +: 8];
  assign ldo2_lowpower_voltage = st_reg.regs[10*8 +: 8];
  assign ldo2_hibernate_voltage = st_reg.regs[11*8 +: 8];
  assign ldo2_highperf_voltage = st_reg.regs[12*8 +: 8];
  assign ldo2_sequencing = st_reg.regs[13*8 +: 8];
  assign ldo2_configuration = st_reg.regs[14*8 +: 8];

endmodule
